// ---- i2cac_map.svh ----
// register offsets, field positions and reset values of the address and command block
`ifndef I2CAC_MAP_SVH
`define I2CAC_MAP_SVH
// register byte addresses
`define I2CAC_OFS_SAR   32'h5002_0308
`define I2CAC_OFS_HSM   32'h5002_030C
`define I2CAC_OFS_CMD   32'h5002_0310
`define I2CAC_OFS_CTL   32'h5002_0380
`define I2CAC_OFS_STAT  32'h5002_0384
// reset values
`define I2CAC_SAR_RST   10'h055
`define I2CAC_HSM_RST   3'h1
`define I2CAC_CTL_RST   3'h2
// fixed upper five bits of the high-speed master code byte
`define I2CAC_HS_PREFIX 5'h01
// command word fields
`define I2CAC_CMD_RD    8
`define I2CAC_CMD_STOP  9
`define I2CAC_CMD_RS    10
`define I2CAC_CMD_W     11
// control register fields
`define I2CAC_CTL_EN    0
`define I2CAC_CTL_RSA   1
`define I2CAC_CTL_A10   2
`endif

// ---- i2cac_pkg.sv ----
// types shared by the address and command block
`default_nettype none
package i2cac_pkg;
  `include "i2cac_map.svh"
  // sequencer states, gray coded along idle-start-byte-active
  typedef enum logic [2:0] {
    SQ_IDLE    = 3'h0,
    SQ_START   = 3'h1,
    SQ_BYTE    = 3'h3,
    SQ_ACTIVE  = 3'h2,
    SQ_RESTART = 3'h6,
    SQ_STOP    = 3'h4
  } i2cac_state_e;
  // operations requested from the bit engine
  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_START   = 3'h1,
    OP_RESTART = 3'h2,
    OP_STOP    = 3'h3,
    OP_WRITE   = 3'h4,
    OP_READ    = 3'h5
  } i2cac_op_e;
  // one queued command, laid out as bits 10:0 of the command word
  typedef struct packed {
    logic       rs;
    logic       stop;
    logic       rd;
    logic [7:0] data;
  } i2cac_cmd_s;
endpackage
`default_nettype wire

// ---- i2cac_seq_if.sv ----
// carrier between the register front end and the condition sequencer
`default_nettype none
interface i2cac_seq_if;
  import i2cac_pkg::*;
  logic         en;          // controller enable
  logic         rs_allowed;  // repeated start allowed
  i2cac_cmd_s   head;        // command at the queue head
  logic         head_valid;  // queue holds a command
  logic         pop;         // take the head command
  i2cac_op_e    op;          // operation for the bit engine
  logic         op_valid;    // operation pending
  logic [7:0]   wdata;       // byte to send
  logic         op_done;     // engine finished the operation
  logic [7:0]   rdata;       // byte received by the engine
  logic [7:0]   rx_byte;     // last received byte
  logic         rx_new;      // rx_byte just updated
  logic         hold_scl;    // stall the clock line low
  i2cac_state_e state;       // sequencer state
  modport seq (input en, rs_allowed, head, head_valid, op_done, rdata,
               output pop, op, op_valid, wdata, rx_byte, rx_new, hold_scl, state);
  modport top (output en, rs_allowed, head, head_valid, op_done, rdata,
               input pop, op, op_valid, wdata, rx_byte, rx_new, hold_scl, state);
endinterface
`default_nettype wire

// ---- i2cac_seq.sv ----
// condition sequencer: places start, restart and stop around each command byte
`default_nettype none
module i2cac_seq
  import i2cac_pkg::*;
(
  // clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  input  wire logic   ce,
  // front end
  i2cac_seq_if.seq    sif
);
  // all sequencer state
  typedef struct packed {
    i2cac_state_e st;       // current state
    i2cac_cmd_s   cmd;      // command being served
    logic         prev_rd;  // direction of the previous byte
    logic         chain;    // start owed after a stop
    i2cac_op_e    op;       // engine operation
    logic         op_valid; // engine request
    logic         pop;      // queue pop pulse
    logic         hold;     // clock stretch
    logic [7:0]   rx;       // received byte
    logic         rx_new;   // received byte pulse
  } i2cac_sq_s;

  localparam i2cac_sq_s SQ_RST = '{st: SQ_IDLE, cmd: '0, prev_rd: 1'b0, chain: 1'b0,
                                   op: OP_NONE, op_valid: 1'b0, pop: 1'b0,
                                   hold: 1'b0, rx: 8'h00, rx_new: 1'b0};

  i2cac_sq_s r_r, r_nxt;
  logic      need_rs;     // head command asks for a new start

  // next state
  always_comb begin
    r_nxt        = r_r;
    r_nxt.pop    = 1'b0;
    r_nxt.rx_new = 1'b0;
    need_rs      = sif.head.rs | (sif.head.rd != r_r.prev_rd);
    unique case (r_r.st)
      SQ_IDLE: begin
        r_nxt.hold = 1'b0;
        // queued work after a stop starts a fresh transfer at once
        if (sif.en && sif.head_valid && !r_r.pop) begin
          r_nxt.pop      = 1'b1;
          r_nxt.cmd      = sif.head;
          r_nxt.st       = SQ_START;
          r_nxt.op       = OP_START;
          r_nxt.op_valid = 1'b1;
        end
      end
      SQ_START, SQ_RESTART: begin
        if (sif.op_done) begin
          r_nxt.st       = SQ_BYTE;
          r_nxt.op       = r_r.cmd.rd ? OP_READ : OP_WRITE;
          r_nxt.op_valid = 1'b1;
        end
      end
      SQ_BYTE: begin
        if (sif.op_done) begin
          r_nxt.prev_rd  = r_r.cmd.rd;
          r_nxt.op_valid = 1'b0;
          r_nxt.op       = OP_NONE;
          if (r_r.cmd.rd) begin
            r_nxt.rx     = sif.rdata;
            r_nxt.rx_new = 1'b1;
          end
          if (r_r.cmd.stop) begin
            r_nxt.st       = SQ_STOP;
            r_nxt.op       = OP_STOP;
            r_nxt.op_valid = 1'b1;
            r_nxt.chain    = 1'b0;
          end else begin
            r_nxt.st = SQ_ACTIVE;
          end
        end
      end
      SQ_ACTIVE: begin
        if (sif.head_valid && !r_r.pop) begin
          r_nxt.pop      = 1'b1;
          r_nxt.cmd      = sif.head;
          r_nxt.hold     = 1'b0;
          r_nxt.op_valid = 1'b1;
          if (!need_rs) begin
            r_nxt.st = SQ_BYTE;
            r_nxt.op = sif.head.rd ? OP_READ : OP_WRITE;
          end else if (sif.rs_allowed) begin
            r_nxt.st = SQ_RESTART;
            r_nxt.op = OP_RESTART;
          end else begin
            r_nxt.st    = SQ_STOP;
            r_nxt.op    = OP_STOP;
            r_nxt.chain = 1'b1;
          end
        end else begin
          r_nxt.hold = 1'b1;
        end
      end
      SQ_STOP: begin
        if (sif.op_done) begin
          if (r_r.chain) begin
            r_nxt.chain = 1'b0;
            r_nxt.st    = SQ_START;
            r_nxt.op    = OP_START;
          end else begin
            r_nxt.st       = SQ_IDLE;
            r_nxt.op       = OP_NONE;
            r_nxt.op_valid = 1'b0;
          end
        end
      end
      default: r_nxt = SQ_RST;           // illegal code recovers to idle
    endcase
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r_r <= SQ_RST;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the register
  assign sif.pop      = r_r.pop;
  assign sif.op       = r_r.op;
  assign sif.op_valid = r_r.op_valid;
  assign sif.wdata    = r_r.cmd.data;
  assign sif.rx_byte  = r_r.rx;
  assign sif.rx_new   = r_r.rx_new;
  assign sif.hold_scl = r_r.hold;
  assign sif.state    = r_r.st;
endmodule
`default_nettype wire

// ---- i2cac_top.sv ----
// own address, high-speed master code and command word block with Wishbone slave
//
// How it works
// - slave answers to 10-bit own address, reset 0x55
// - 7-bit mode compares own address bits 6:0
// - own address writable only while disabled
// - 3-bit master code, reset 1, values 0-7
// - code byte is 00001 then master code
// - master code writable only while disabled
// - restart bit forces repeated start when allowed
// - without restart bit, restart on direction change
// - restarts disallowed: stop then start instead
// - stop bit issues stop after that byte
// - queued commands after stop start new transfer
// - no stop bit means no stop issued, except in place of a disallowed restart
// - no stop: continue transfer per direction bit
// - empty queue without stop holds clock low
// - command bit 8 picks master read or write
// - reads ignore byte field; read returns rx byte
//
// Register access over Wishbone was decided locally.
`default_nettype none
`include "i2cac_map.svh"
module i2cac_top
  import i2cac_pkg::*;
#(
  parameter int unsigned WB_AW = 32     // wishbone address width
)(
  // clock, reset, clock enable
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // wishbone classic slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [WB_AW-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // transmit command queue, push side
  output logic                  txq_push,
  output logic      [10:0]      txq_word,
  input  wire logic             txq_full,
  // transmit command queue, drain side
  input  wire logic             txq_valid,
  input  wire logic [10:0]      txq_head,
  output logic                  txq_pop,
  // bit engine
  output logic      [2:0]       eng_op,
  output logic                  eng_op_valid,
  output logic      [7:0]       eng_wdata,
  input  wire logic             eng_done,
  input  wire logic [7:0]       eng_rdata,
  output logic                  scl_hold,
  // slave address check
  input  wire logic             slv_addr_valid,
  input  wire logic [9:0]       slv_addr,
  output logic                  slv_match,
  // settings for the neighbouring logic
  output logic      [7:0]       hs_code_byte,
  output logic                  ctl_enable,
  output logic                  ctl_restart_allowed,
  output logic                  ctl_addr10
);

  ////////////////////////////////////////////////////////////////////
  // elaboration check

  // the decoder compares full 32-bit byte addresses
  generate
    if (WB_AW != 32) begin : g_bad_aw
      $error("WB_AW must be 32");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // state

  // all front end state in one record
  typedef struct packed {
    logic [9:0]  sar;      // own_address_field
    logic [2:0]  hsm;      // hs_master_code_field
    logic        en;       // controller_enable_bit
    logic        rsa;      // restart_allowed
    logic        a10;      // 10-bit slave addressing
    logic        ack;      // bus acknowledge
    logic [31:0] dat;      // bus read data
    logic        push;     // queue push pulse
    logic [10:0] word;     // pushed command
    logic        match;    // address match pulse
    logic [7:0]  code;     // master code byte
    logic [7:0]  rx;       // byte_payload as last received
  } i2cac_top_s;

  localparam logic [2:0] CTL_RST = `I2CAC_CTL_RST;

  localparam i2cac_top_s TOP_RST = '{
    sar:   `I2CAC_SAR_RST,
    hsm:   `I2CAC_HSM_RST,
    en:    CTL_RST[`I2CAC_CTL_EN],
    rsa:   CTL_RST[`I2CAC_CTL_RSA],
    a10:   CTL_RST[`I2CAC_CTL_A10],
    ack:   1'b0,
    dat:   32'h0000_0000,
    push:  1'b0,
    word:  11'h000,
    match: 1'b0,
    code:  {`I2CAC_HS_PREFIX, `I2CAC_HSM_RST},
    rx:    8'h00
  };

  i2cac_top_s r_r, r_nxt;

  ////////////////////////////////////////////////////////////////////
  // sequencer

  i2cac_seq_if sif ();

  // settings and queue head toward the sequencer
  assign sif.en         = r_r.en;
  assign sif.rs_allowed = r_r.rsa;
  assign sif.head       = i2cac_cmd_s'(txq_head);
  assign sif.head_valid = txq_valid;
  assign sif.op_done    = eng_done;
  assign sif.rdata      = eng_rdata;

  // sequencer owns start, restart, stop placement and clock stretch
  i2cac_seq u_seq (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .sif (sif.seq)
  );

  ////////////////////////////////////////////////////////////////////
  // byte lane mask

  // one mask byte per select line
  logic [31:0] wmask;
  genvar gl;
  generate
    for (gl = 0; gl < 4; gl++) begin : g_lane
      assign wmask[gl*8 +: 8] = {8{wb_sel_i[gl]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // next state

  logic        req;        // new access not yet answered
  logic        hit_sar;    // own address register selected
  logic        hit_hsm;    // master code register selected
  logic        hit_cmd;    // command register selected
  logic        hit_ctl;    // control register selected
  logic        hit_stat;   // status register selected
  logic [31:0] wr_sar;     // lane-merged own address
  logic [31:0] wr_hsm;     // lane-merged master code
  logic [31:0] wr_ctl;     // lane-merged control
  logic        cmp_hit;    // address compare result

  always_comb begin
    r_nxt    = r_r;
    r_nxt.ack  = 1'b0;
    r_nxt.push = 1'b0;
    // a request is taken only once; ack drops in the following cycle
    req      = wb_cyc_i & wb_stb_i & ~r_r.ack;
    hit_sar  = (wb_adr_i == `I2CAC_OFS_SAR);
    hit_hsm  = (wb_adr_i == `I2CAC_OFS_HSM);
    hit_cmd  = (wb_adr_i == `I2CAC_OFS_CMD);
    hit_ctl  = (wb_adr_i == `I2CAC_OFS_CTL);
    hit_stat = (wb_adr_i == `I2CAC_OFS_STAT);
    // merge written lanes with the current contents
    wr_sar   = (wb_dat_i & wmask) | ({22'h000000, r_r.sar} & ~wmask);
    wr_hsm   = (wb_dat_i & wmask) | ({29'h00000000, r_r.hsm} & ~wmask);
    wr_ctl   = (wb_dat_i & wmask) | ({29'h00000000, r_r.a10, r_r.rsa, r_r.en} & ~wmask);

    if (req) begin
      r_nxt.ack = 1'b1;
      if (wb_we_i) begin
        // write side
        if (hit_sar) begin
          // a write while enabled is dropped but still answered
          if (!r_r.en) begin
            r_nxt.sar = wr_sar[9:0];
          end
        end else if (hit_hsm) begin
          if (!r_r.en) begin
            r_nxt.hsm = wr_hsm[2:0];
          end
        end else if (hit_cmd) begin
          // full queue stalls the answer rather than losing the command
          if (txq_full) begin
            r_nxt.ack = 1'b0;
          end else begin
            r_nxt.push = 1'b1;
            r_nxt.word = wb_dat_i[10:0];
          end
        end else if (hit_ctl) begin
          r_nxt.en  = wr_ctl[`I2CAC_CTL_EN];
          r_nxt.rsa = wr_ctl[`I2CAC_CTL_RSA];
          r_nxt.a10 = wr_ctl[`I2CAC_CTL_A10];
        end
        r_nxt.dat = 32'h0000_0000;
      end else begin
        // read side; unmapped addresses answer with zero
        if (hit_sar) begin
          r_nxt.dat = {22'h000000, r_r.sar};
        end else if (hit_hsm) begin
          r_nxt.dat = {29'h00000000, r_r.hsm};
        end else if (hit_cmd) begin
          // control bits are write only; the byte is the last received
          r_nxt.dat = {24'h000000, r_r.rx};
        end else if (hit_ctl) begin
          r_nxt.dat = {29'h00000000, r_r.a10, r_r.rsa, r_r.en};
        end else if (hit_stat) begin
          r_nxt.dat = {24'h000000, txq_valid, txq_full, sif.op_valid,
                       sif.hold_scl, 1'b0, sif.state};
        end else begin
          r_nxt.dat = 32'h0000_0000;
        end
      end
    end

    // capture each byte the engine received on a read command
    if (sif.rx_new) begin
      r_nxt.rx = sif.rx_byte;
    end

    // master code byte follows the field
    r_nxt.code = {`I2CAC_HS_PREFIX, r_r.hsm};

    // own address compare; upper bits ignored in 7-bit mode
    if (r_r.a10) begin
      cmp_hit = (slv_addr == r_r.sar);
    end else begin
      cmp_hit = (slv_addr[6:0] == r_r.sar[6:0]);
    end
    r_nxt.match = slv_addr_valid & cmp_hit;
  end

  ////////////////////////////////////////////////////////////////////
  // state register

  // clock enable low freezes everything
  always_ff @(posedge clk) begin
    if (rst) begin
      r_r <= TOP_RST;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // outputs

  // bus
  assign wb_dat_o            = r_r.dat;
  assign wb_ack_o            = r_r.ack;
  // queue
  assign txq_push            = r_r.push;
  assign txq_word            = r_r.word;
  assign txq_pop             = sif.pop;
  // engine, registered inside the sequencer
  assign eng_op              = sif.op;
  assign eng_op_valid        = sif.op_valid;
  assign eng_wdata           = sif.wdata;
  assign scl_hold            = sif.hold_scl;
  // address and settings
  assign slv_match           = r_r.match;
  assign hs_code_byte        = r_r.code;
  assign ctl_enable          = r_r.en;
  assign ctl_restart_allowed = r_r.rsa;
  assign ctl_addr10          = r_r.a10;
endmodule
`default_nettype wire

// ---- i2cac_far.sv ----
// far-side model: transmit command queue and bit engine
`default_nettype none
module i2cac_far #(
  parameter int DEPTH = 8        // queue slots
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // queue push and drain
  input  wire logic        push,
  input  wire logic [10:0] word,
  output logic             full,
  output logic             valid,
  output logic      [10:0] head,
  input  wire logic        pop,
  // bit engine
  input  wire logic        opv,
  output logic             done,
  output logic      [7:0]  rdata,
  // random lag and received byte
  input  wire logic [1:0]  lag,
  input  wire logic [7:0]  rnd
);
  logic [10:0] q[$];             // queued commands
  int          cnt;              // cycles spent on current op
  ////////////////////////////////////////////////////////////////////////
  // queue: pop before push so a full queue can still take a word
  always @(posedge clk) begin
    if (rst) begin
      q.delete();
      valid <= 1'b0;
      full  <= 1'b0;
      head  <= 11'h000;
    end else begin
      if (pop && q.size() > 0) q.pop_front();
      if (push) q.push_back(word);
      valid <= q.size() > 0;
      full  <= q.size() >= DEPTH;
      // empty head shows garbage: the last command and its inverse by turns
      head  <= q.size() > 0 ? q[0] : ~head;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // engine: finishes after a random lag, skips the cycle after a done
  always @(posedge clk) begin
    if (rst) begin
      done <= 1'b0;
      cnt  <= 0;
    end else if (done) begin
      done <= 1'b0;
    end else if (opv && cnt >= int'(lag)) begin
      done  <= 1'b1;
      rdata <= rnd;
      cnt   <= 0;
    end else begin
      cnt   <= opv ? cnt + 1 : 0;
      rdata <= ~rdata;            // byte only valid with done
    end
  end
endmodule
`default_nettype wire

// ---- i2cac_checker.sv ----
// port assertions of the address and command block
`default_nettype none
`include "i2cac_map.svh"
module i2cac_chk #(
  parameter int unsigned WB_AW = 32
)(
  // clock, reset, enable and bus
  input wire logic clk, rst, ce, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
  input wire logic [WB_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i, wb_dat_o,
  // queue, engine, address match and settings
  input wire logic txq_push, txq_full, txq_valid, txq_pop, eng_op_valid, eng_done,
  input wire logic scl_hold, slv_addr_valid, slv_match, ctl_enable,
  input wire logic ctl_restart_allowed, ctl_addr10,
  input wire logic [10:0] txq_word, txq_head,
  input wire logic [2:0] eng_op,
  input wire logic [7:0] eng_wdata, eng_rdata, hs_code_byte,
  input wire logic [9:0] slv_addr
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic cmd_w;                   // bus write names the command word
  assign cmd_w = wb_we_i && wb_adr_i == WB_AW'(`I2CAC_OFS_CMD);
  ////////////////////////////////////////////////////////////////////////
  property p_ack_turn;           // every other access is answered next cycle
    wb_cyc_i && wb_stb_i && !wb_ack_o && ce && !cmd_w |=> wb_ack_o;
  endproperty
  a_ack_turn: assert property (p_ack_turn) else $error("bus access not acked");
  property p_hs_byte;
    hs_code_byte[7:3] == 5'h01;
  endproperty
  a_hs_byte: assert property (p_hs_byte) else $error("code byte prefix wrong");
  property p_push_word;
    wb_ack_o && cmd_w |-> txq_push && txq_word == wb_dat_i[10:0];
  endproperty
  a_push_word: assert property (p_push_word) else $error("command not queued");
  property p_push_cause;
    txq_push |-> wb_ack_o && cmd_w && !$past(txq_full);
  endproperty
  a_push_cause: assert property (p_push_cause) else $error("stray queue push");
  property p_pop_cause;          // a pop never outruns the queue
    txq_pop && ce |-> $past(txq_valid) ##1 !txq_pop;
  endproperty
  a_pop_cause: assert property (p_pop_cause) else $error("pop without command");
  property p_op_hold;
    eng_op_valid && !eng_done |=> eng_op_valid && $stable(eng_op) && $stable(eng_wdata);
  endproperty
  a_op_hold: assert property (p_op_hold) else $error("engine op changed early");
  property p_op_code;
    eng_op_valid |-> eng_op inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
  endproperty
  a_op_code: assert property (p_op_code) else $error("engine op code bad");
  property p_hold_idle;          // clock held only with no op pending
    $rose(scl_hold) |-> !eng_op_valid && !txq_pop;
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("hold during op");
  property p_match_cause;
    slv_match |-> $past(slv_addr_valid);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without address");
  c_push: cover property (txq_push);
  c_restart: cover property (eng_op_valid && eng_op == 3'h2);
  c_stop: cover property (eng_op_valid && eng_op == 3'h3);
  c_hold: cover property (scl_hold);
endmodule
`default_nettype wire

// ---- i2cac_top_tb.sv ----
// self-checking bench for the address and command block
`default_nettype none
`include "i2cac_map.svh"
module i2cac_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // bus and stimulus
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, sav = 0;
  logic [31:0] adr = 0, wdat = 0, rdat, dat_o;
  logic [3:0] sel = 0;
  logic [9:0] saddr = 0, sar;
  logic [1:0] lag = 0;
  logic [7:0] rnd = 0, last_rx = 0, wd, rd, hs;
  // block outputs and far-side wires
  logic ack, push, full, valid, pop, opv, done, hold, mtch, en, ra, a10;
  logic [10:0] word, head, c;
  logic [2:0] op;
  int n_mismatch = 0, checks = 0, seed = 66, cyc_n = 0, v;
  int got[$], exp_q[$];
  logic [10:0] cmds[$];          // commands of the current burst
  always #25 clk = ~clk;
  i2cac_top dut (.clk, .rst, .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .txq_push(push), .txq_word(word), .txq_full(full), .txq_valid(valid), .txq_head(head),
    .txq_pop(pop), .eng_op(op), .eng_op_valid(opv), .eng_wdata(wd), .eng_done(done),
    .eng_rdata(rd), .scl_hold(hold), .slv_addr_valid(sav), .slv_addr(saddr),
    .slv_match(mtch), .hs_code_byte(hs), .ctl_enable(en), .ctl_restart_allowed(ra),
    .ctl_addr10(a10));
  i2cac_far far (.clk, .rst, .push, .word, .full, .valid, .head, .pop, .opv, .done,
    .rdata(rd), .lag, .rnd);
  ////////////////////////////////////////////////////////////////////////
  // random lag and received bytes; hang cut-off
  always @(posedge clk) begin
    lag <= 2'($random(seed));
    rnd <= 8'($random(seed));
    cyc_n++;
    if (cyc_n == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  // log each finished engine op, with its byte for writes and zero for reads
  always @(negedge clk) begin
    if (!rst && opv === 1'b1 && done) begin
      got.push_back(int'({op, op == 3'h4 ? wd : 8'h00}));
      if (op == 3'h5) last_rx = rd;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, exp_v);
    checks++;
    if (seen !== exp_v) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp_v, seen);
    end
  endtask
  // one classic cycle; ack and read data taken at the edge that sees ack high
  task automatic wb(input logic w, input logic [31:0] a, d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 200);
    if (ack !== 1'b1) n_mismatch++;
    rdat = dat_o;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic match(input logic [9:0] a, input logic e);
    @(posedge clk);
    {sav, saddr} <= {1'b1, a};
    @(posedge clk);
    {sav, saddr} <= {1'b0, ~a};   // released lines show garbage
    @(negedge clk);
    chk("address match", mtch, e);
  endtask
  // expected engine ops, one entry {op, byte} per op
  task automatic model(input bit rav);
    bit act, pd;
    act = 0;
    pd = 0;
    exp_q.delete();
    foreach (cmds[i]) begin
      if (!act) exp_q.push_back(1 << 8);
      else if (cmds[i][10] || cmds[i][8] != pd) begin
        if (rav) exp_q.push_back(2 << 8);
        else exp_q.push_back(3 << 8);
        if (!rav) exp_q.push_back(1 << 8);
      end
      exp_q.push_back(cmds[i][8] ? 5 << 8 : (4 << 8) + cmds[i][7:0]);
      pd = cmds[i][8];
      act = !cmds[i][9];
      if (cmds[i][9]) exp_q.push_back(3 << 8);
    end
    v = 0;
    while (got.size() < exp_q.size() && v < 2000) begin
      @(negedge clk);
      v++;
    end
    repeat (3) @(negedge clk);
    chk("op count", got.size(), exp_q.size());
    foreach (exp_q[i]) chk("engine op", got[i], exp_q[i]);
  endtask
  // six queued commands, a stall, then a stop-flagged seventh
  task automatic burst(input bit rav);
    cmds.delete();
    got.delete();
    for (int i = 0; i < 7; i++) begin
      c = 11'($random(seed));
      if (i == 0 || cmds[i-1][9]) c[10] = 1'b0;
      c[9] = i == 6 ? 1'b1 : (i == 5 ? 1'b0 : c[9]);
      cmds.push_back(c);
      if (i < 6) wb(1, `I2CAC_OFS_CMD, {21'h0, c});
    end
    c = cmds.pop_back();
    wb(1, `I2CAC_OFS_CTL, {30'h0, rav, 1'b1});
    model(rav);
    chk("clock hold", hold, 1'b1);
    wb(0, `I2CAC_OFS_STAT, 0);
    chk("status", rdat, 32'h12);
    cmds.push_back(c);
    wb(1, `I2CAC_OFS_CMD, {21'h0, c});
    model(rav);
    chk("clock hold", hold, 1'b0);
    wb(0, `I2CAC_OFS_CMD, 0);
    chk("received byte", rdat[7:0], last_rx);
    wb(1, `I2CAC_OFS_CTL, {30'h0, rav, 1'b0});
    $display("burst with restart allowed %0d done", rav);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wb(0, `I2CAC_OFS_SAR, 0);
    chk("own address", rdat, 32'h55);
    wb(0, `I2CAC_OFS_HSM, 0);
    chk("master code", rdat, 32'h1);
    chk("code byte", hs, 8'h09);
    wb(0, 32'h5002_03F0, 0);
    chk("unmapped read", rdat, 32'h0);
    $display("reset values done");
    repeat (3) begin
      v = $random(seed);
      wb(1, `I2CAC_OFS_SAR, v);
      wb(1, `I2CAC_OFS_HSM, v >> 12);
      wb(0, `I2CAC_OFS_SAR, 0);
      chk("own address", rdat, v & 32'h3FF);
      wb(0, `I2CAC_OFS_HSM, 0);
      chk("master code", rdat, (v >> 12) & 32'h7);
      chk("code byte", hs, {5'h01, 3'(v >> 12)});
    end
    sar = 10'(v);
    wb(1, `I2CAC_OFS_CTL, 32'h3);
    chk("enable", {en, ra, a10}, 3'b110);
    match(sar ^ 10'h380, 1'b1);
    match(sar ^ 10'h001, 1'b0);
    wb(1, `I2CAC_OFS_CTL, 32'h7);
    match(sar ^ 10'h380, 1'b0);
    match(sar, 1'b1);
    wb(1, `I2CAC_OFS_SAR, ~v);
    wb(1, `I2CAC_OFS_HSM, ~(v >> 12));
    wb(0, `I2CAC_OFS_SAR, 0);
    chk("locked address", rdat, v & 32'h3FF);
    wb(0, `I2CAC_OFS_HSM, 0);
    chk("locked code", rdat, (v >> 12) & 32'h7);
    wb(1, `I2CAC_OFS_CTL, 32'h2);
    $display("address and code done");
    burst(1'b1);
    burst(1'b0);
    burst(1'b1);
    report_and_stop();
  end
endmodule
bind i2cac_top i2cac_chk #(.WB_AW(WB_AW)) chk_u (.clk, .rst, .ce, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .txq_push, .txq_full,
  .txq_valid, .txq_pop, .eng_op_valid, .eng_done, .scl_hold, .slv_addr_valid, .slv_match,
  .ctl_enable, .ctl_restart_allowed, .ctl_addr10, .txq_word, .txq_head, .eng_op,
  .eng_wdata, .eng_rdata, .hs_code_byte, .slv_addr);
`default_nettype wire
